// ===== pkg/gauge_pm_regs.vh
// constants for the gauge power-mode and status controller
`ifndef GAUGE_PM_REGS_VH
`define GAUGE_PM_REGS_VH
// register offsets
`define A_CFG 4'h0
`define A_CHGV 4'h1
`define A_OTC_THR 4'h2
`define A_OTC_REC 4'h3
`define A_OTC_TIME 4'h4
`define A_OTD_THR 4'h5
`define A_OTD_TIME 4'h6
`define A_INH 4'h7
`define A_CUR 4'h8
`define A_MEAS 4'h9
`define A_CTRL 4'hA
`define A_STAT 4'hB
`define A_RSTCNT 4'hC
`define A_CAP 4'hD
`define A_TAPER 4'hE
`define A_PERIOD 4'hF
// configuration bits
`define CFG_THERMISTOR_SOURCE_SELECT 0
`define CFG_FILL_REMAINING_ON_TERMINATION 4
`define CFG_SLEEP 5
`define CFG_PFC0 11
`define CFG_PFC1 12
`define CFG_RESET 16'h0931
// control bits
`define CTL_FAST_OSCILLATOR_SLEEP_ENABLE 0
`define CTL_HIB 1
`define CTL_RESET 2
`define CTL_PARTIAL 3
`define CTL_OCV_OK 4
`define CTL_RAM_WR 5
// defaults
`define CHGV_RESET 16'h1068
`define PERIOD_RESET 16'h0FA0
`define TAPER_WINDOWS 2'h2
`define INSERT_DELAY_S 2
`define CLK_HZ 40000000
// power modes
`define M_NORMAL 3'h0
`define M_SLEEP 3'h1
`define M_FAST_OSCILLATOR_SLEEP_ENABLE 3'h2
`define M_INSERT 3'h3
`define M_HIB 3'h4
`define M_CAL 3'h5
`endif

// ===== design/gauge_power_mode_status_ctrl.v
// status and power-mode controller of a single-cell battery monitor
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "gauge_pm_regs.vh"
//
// Contract
// - thermistor unless source-select bit cleared
// - charge overtemp after hold, current above threshold
// - charge overtemp clears at recovery level
// - zero hold time disables that detection
// - discharge overtemp after hold, current low
// - charging voltage programmable, default 4200 mV
// - termination: two taper windows plus voltage
// - termination fills remaining capacity if enabled
// - function 1: pin high outside inhibit range
// - pin low again inside hysteresis band
// - functions 0/2: temperature sampled on query (only while charging; every cycle otherwise)
// - normal mode when no other mode
// - sleep entry after autocalibration when enabled
// - sleep exit on current or wake
// - fast-wake sleep on control bit, low current
// - fast-wake exit on bus, current, wake
// - wait insertion, then measure, assert good
// - insertion wait wakes for host commands
// - deep low-power after request, ocv, current, or when voltage below taper_q
// - deep low-power left only by addressed command
// - software reset classified and counted
// - partial reset checks ram checksum
// - two-bit function code, default function 1
module gauge_power_mode_status_ctrl #(
   parameter INSERT_CYCLES = `INSERT_DELAY_S * `CLK_HZ
) (
   input wire clk_i,
   input wire nrst_i,
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   input wire [15:0] thermistor_input_i,
   input wire [15:0] internal_temp_i,
   input wire [15:0] voltage_i,
   input wire [15:0] avg_current_i,
   input wire [15:0] cap_change_i,
   input wire taper_tick_i,
   input wire wake_i,
   input wire bus_addressed_i,
   input wire battery_present_i,
   input wire ext_power_i,
   input wire temp_query_i,
   input wire cal_done_i,
   input wire link_scl_i,
   output reg battery_status_pin_o,
   output reg battery_good_o,
   output reg charge_overtemp_flag_o,
   output reg discharge_overtemp_flag_o,
   output reg charging_o,
   output reg measure_tick_o,
   output reg cal_start_o,
   output reg ram_reinit_o,
   output reg [2:0] mode_o
);
   // configuration and thresholds (signed temperatures, currents)
   reg [15:0] cfg_q, chgv_q, otc_thr_q, otc_rec_q, otc_time_q, otd_thr_q, otd_time_q;
   reg [15:0] inh_q, cur_q, meas_q, ctrl_q, cap_q, taper_q, period_q;
   reg [15:0] temp_q, otc_cnt_q, otd_cnt_q, per_cnt_q, rst_cnt_q, ram_sum_q, ram_val_q;
   reg [31:0] ins_cnt_q;
   reg [1:0] taper_cnt_q;
   reg [1:0] scl_s_q;
   reg scl_prev_q;
   reg [1:0] pres_s_q;
   reg [1:0] wake_s_q;
   reg [1:0] ext_s_q;
   reg charge_inh_q;
   wire [15:0] raw_temp;
   wire [1:0] pin_func;
   wire sleep_req, insert_done, fast_oscillator_sleep_enable_req, hib_req;
   wire scl_edge;

   // signed compare helper
   function ge_s;
      input [15:0] a;
      input [15:0] b;
      begin
         ge_s = ($signed(a) >= $signed(b));
      end
   endfunction

   assign pin_func = {cfg_q[`CFG_PFC1], cfg_q[`CFG_PFC0]};
   assign raw_temp = cfg_q[`CFG_THERMISTOR_SOURCE_SELECT] ? thermistor_input_i : internal_temp_i;
   // current below sleep threshold (cur_q low byte = sleep current)
   assign sleep_req = $signed(avg_current_i) < $signed({8'h00, cur_q[7:0]});
   assign fast_oscillator_sleep_enable_req = ctrl_q[`CTL_FAST_OSCILLATOR_SLEEP_ENABLE] & sleep_req;
   assign hib_req = (ctrl_q[`CTL_HIB] & ctrl_q[`CTL_OCV_OK]
                     & ($signed(avg_current_i) < $signed({8'h00, cur_q[15:8]})
                     & $signed(avg_current_i) > -$signed({8'h00, cur_q[15:8]})))
                    | ($signed(voltage_i) < $signed(taper_q));
   assign insert_done = (ins_cnt_q == 32'h0);
   assign scl_edge = scl_s_q[1] & ~scl_prev_q;

   // taper window evaluation
   wire taper_ok = ($signed(avg_current_i) < $signed({8'h00, taper_q[7:0]}))
                   & (cap_change_i > {8'h00, taper_q[15:8]});
   wire term_now = taper_tick_i & taper_ok & (taper_cnt_q == `TAPER_WINDOWS - 2'h1)
                   & (voltage_i > chgv_q - meas_q);
   // inhibit window: low/high from the measurement-offset register
   wire [7:0] chgv_lo = cfg_q[15] ? 8'h00 : ram_val_q[7:0];
   wire [7:0] chgv_hi = ram_val_q[15:8];
   wire signed [15:0] hys = {12'h000, cfg_q[14:13], 2'h0};

   // synchronisers for pin-level inputs
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_s_q <= 2'h0;
         scl_prev_q <= 1'b0;
         pres_s_q <= 2'h0;
         wake_s_q <= 2'h0;
         ext_s_q <= 2'h0;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], link_scl_i};
         scl_prev_q <= scl_s_q[1];
         pres_s_q <= {pres_s_q[0], battery_present_i};
         wake_s_q <= {wake_s_q[0], wake_i};
         ext_s_q <= {ext_s_q[0], ext_power_i};
      end
   end

   // register writes and bus reads
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg_q <= `CFG_RESET;
         chgv_q <= `CHGV_RESET;
         otc_thr_q <= 16'h0000;
         otc_rec_q <= 16'h0000;
         otc_time_q <= 16'h0000;
         otd_thr_q <= 16'h0000;
         otd_time_q <= 16'h0000;
         inh_q <= 16'h0000;
         cur_q <= 16'h0000;
         meas_q <= 16'h0000;
         ctrl_q <= 16'h0000;
         cap_q <= 16'h0000;
         taper_q <= 16'h0000;
         period_q <= `PERIOD_RESET;
         rdata_o <= 16'h0000;
      end
      else
      begin
         ctrl_q[`CTL_RESET] <= 1'b0;
         ctrl_q[`CTL_RAM_WR] <= 1'b0;
         if (wr_i)
         begin
            case (addr_i)
               `A_CFG: cfg_q <= wdata_i;
               `A_CHGV: chgv_q <= wdata_i;
               `A_OTC_THR: otc_thr_q <= wdata_i;
               `A_OTC_REC: otc_rec_q <= wdata_i;
               `A_OTC_TIME: otc_time_q <= wdata_i;
               `A_OTD_THR: otd_thr_q <= wdata_i;
               `A_OTD_TIME: otd_time_q <= wdata_i;
               `A_INH: inh_q <= wdata_i;
               `A_CUR: cur_q <= wdata_i;
               `A_MEAS: meas_q <= wdata_i;
               `A_CTRL: ctrl_q <= wdata_i;
               `A_TAPER: taper_q <= wdata_i;
               `A_PERIOD: period_q <= wdata_i;
               default: ;
            endcase
         end
         if (charging_o & term_now & cfg_q[`CFG_FILL_REMAINING_ON_TERMINATION])
            cap_q <= {8'h00, cap_q[15:8]} << 8 | {8'h00, cap_q[15:8]};
         else if (wr_i && addr_i == `A_CAP)
            cap_q <= wdata_i;
         if (rd_i)
         begin
            case (addr_i)
               `A_CFG: rdata_o <= cfg_q;
               `A_CHGV: rdata_o <= chgv_q;
               `A_CTRL: rdata_o <= ctrl_q;
               `A_STAT: rdata_o <= {5'h00, battery_good_o, battery_status_pin_o, charging_o,
                  discharge_overtemp_flag_o, charge_overtemp_flag_o, 3'h0, mode_o};
               `A_MEAS: rdata_o <= temp_q;
               `A_RSTCNT: rdata_o <= rst_cnt_q;
               `A_CAP: rdata_o <= cap_q;
               `A_PERIOD: rdata_o <= period_q;
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // temperature tracking, flags, termination
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         temp_q <= 16'h0000;
         otc_cnt_q <= 16'h0000;
         otd_cnt_q <= 16'h0000;
         charge_overtemp_flag_o <= 1'b0;
         discharge_overtemp_flag_o <= 1'b0;
         charging_o <= 1'b0;
         taper_cnt_q <= 2'h0;
         charge_inh_q <= 1'b0;
         battery_status_pin_o <= 1'b0;
      end
      else
      begin
         // on-query sampling while charging in functions 0/2
         if (!(charging_o && pin_func != 2'h1) || temp_query_i)
            temp_q <= raw_temp;
         if ($signed(avg_current_i) > 0)
            charging_o <= 1'b1;
         if (taper_tick_i)
            taper_cnt_q <= taper_ok ? ((taper_cnt_q == `TAPER_WINDOWS) ? taper_cnt_q
                                       : taper_cnt_q + 2'h1) : 2'h0;
         if (charging_o & term_now)
            charging_o <= 1'b0;
         if (charging_o && ge_s(temp_q, otc_thr_q) && otc_time_q != 16'h0000
             && $signed(avg_current_i) > $signed({8'h00, inh_q[7:0]}))
            otc_cnt_q <= (otc_cnt_q == otc_time_q) ? otc_cnt_q : otc_cnt_q + 16'h0001;
         else
            otc_cnt_q <= 16'h0000;
         // zero hold time never sets flag
         if (otc_time_q != 16'h0000 && otc_cnt_q == otc_time_q)
            charge_overtemp_flag_o <= 1'b1;
         else if (!ge_s(temp_q, otc_rec_q + 16'h0001) || otc_time_q == 16'h0000)
            charge_overtemp_flag_o <= 1'b0;
         if (!charging_o && ge_s(temp_q, otd_thr_q) && otd_time_q != 16'h0000
             && $signed(avg_current_i) <= -$signed({8'h00, inh_q[15:8]}))
            otd_cnt_q <= (otd_cnt_q == otd_time_q) ? otd_cnt_q : otd_cnt_q + 16'h0001;
         else
            otd_cnt_q <= 16'h0000;
         if (otd_time_q != 16'h0000 && otd_cnt_q == otd_time_q)
            discharge_overtemp_flag_o <= 1'b1;
         else if (otd_time_q == 16'h0000 || !ge_s(temp_q, otd_thr_q))
            discharge_overtemp_flag_o <= 1'b0;
         // inhibit outside thresholds (cfg_q bits 14:13 set hysteresis, in steps of 4)
         if ($signed(temp_q) < $signed({{8{chgv_lo[7]}}, chgv_lo})
             || $signed(temp_q) > $signed({{8{chgv_hi[7]}}, chgv_hi}))
            charge_inh_q <= 1'b1;
         else if ($signed(temp_q) >= $signed({{8{chgv_lo[7]}}, chgv_lo}) + hys
                  && $signed(temp_q) <= $signed({{8{chgv_hi[7]}}, chgv_hi}) - hys)
            charge_inh_q <= 1'b0;
         battery_status_pin_o <= (pin_func == 2'h1) ? (charge_inh_q | ~battery_good_o)
                                                    : ~battery_good_o;
      end
   end
   // power mode sequencer
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_o <= `M_NORMAL;
         per_cnt_q <= 16'h0000;
         ins_cnt_q <= 32'h0;
         measure_tick_o <= 1'b0;
         cal_start_o <= 1'b0;
         battery_good_o <= 1'b0;
      end
      else
      begin
         measure_tick_o <= 1'b0;
         cal_start_o <= 1'b0;
         if (mode_o == `M_SLEEP || mode_o == `M_FAST_OSCILLATOR_SLEEP_ENABLE)
         begin
            per_cnt_q <= (per_cnt_q >= period_q) ? 16'h0000 : per_cnt_q + 16'h0001;
            measure_tick_o <= (per_cnt_q >= period_q);
         end
         else
         begin
            per_cnt_q <= 16'h0000;
            measure_tick_o <= (mode_o == `M_NORMAL);
         end
         case (mode_o)
            `M_NORMAL:
               if (!pres_s_q[1] && ext_s_q[1])
               begin
                  mode_o <= `M_INSERT;
                  battery_good_o <= 1'b0;
               end
               else if (hib_req)
               begin
                  mode_o <= `M_HIB;
                  battery_good_o <= 1'b0;
               end
               else if (fast_oscillator_sleep_enable_req)
                  mode_o <= `M_FAST_OSCILLATOR_SLEEP_ENABLE;
               else if (cfg_q[`CFG_SLEEP] && sleep_req)
               begin
                  mode_o <= `M_CAL;
                  cal_start_o <= 1'b1;
               end
            `M_CAL:
               if (!sleep_req || wake_s_q[1])
                  mode_o <= `M_NORMAL;
               else if (cal_done_i)
                  mode_o <= `M_SLEEP;
            `M_SLEEP:
               if (!sleep_req || wake_s_q[1])
                  mode_o <= `M_NORMAL;
            `M_FAST_OSCILLATOR_SLEEP_ENABLE:
               if (bus_addressed_i || scl_edge || !sleep_req || wake_s_q[1])
                  mode_o <= `M_NORMAL;
            `M_INSERT:
               if (pres_s_q[1])
               begin
                  if (ins_cnt_q == 32'h0 && !battery_good_o)
                     ins_cnt_q <= ext_s_q[1] ? 32'h1 : INSERT_CYCLES;
                  else if (ins_cnt_q > 32'h1)
                     ins_cnt_q <= ins_cnt_q - 32'h1;
                  else
                  begin
                     ins_cnt_q <= 32'h0;
                     battery_good_o <= 1'b1;
                     mode_o <= `M_NORMAL;
                  end
               end
               else
                  measure_tick_o <= bus_addressed_i;
            `M_HIB:
               if (bus_addressed_i)
                  mode_o <= `M_INSERT;
            default: mode_o <= `M_NORMAL;
         endcase
      end
   end

   // reset classification and ram checksum
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_cnt_q <= 16'h0000;
         ram_sum_q <= 16'h0000;
         ram_val_q <= 16'h0000;
         ram_reinit_o <= 1'b0;
      end
      else
      begin
         ram_reinit_o <= 1'b0;
         // checksum refreshed on every ram write
         if (wr_i && addr_i == `A_MEAS)
         begin
            ram_val_q <= wdata_i;
            ram_sum_q <= ~wdata_i;
         end
         if (wr_i && addr_i == `A_CTRL && wdata_i[`CTL_RESET])
         begin
            if (wdata_i[`CTL_PARTIAL])
            begin
               rst_cnt_q[7:0] <= rst_cnt_q[7:0] + 8'h01;
               if (ram_sum_q != ~ram_val_q)
               begin
                  ram_reinit_o <= 1'b1;
                  ram_val_q <= 16'h0000;
                  ram_sum_q <= 16'hFFFF;
               end
            end
            else
            begin
               rst_cnt_q[15:8] <= rst_cnt_q[15:8] + 8'h01;
               ram_reinit_o <= 1'b1;
               ram_val_q <= 16'h0000;
               ram_sum_q <= 16'hFFFF;
            end
         end
      end
   end
endmodule // gauge_power_mode_status_ctrl
`default_nettype wire

// ===== verification/gauge_pm_properties.sv
// port-level checks for the gauge controller
`timescale 1ns/100ps
`default_nettype none
`include "gauge_pm_regs.vh"
module gauge_pm_properties (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic bus_addressed_i,
   input wire logic battery_present_i,
   input wire logic battery_good_o,
   input wire logic charge_overtemp_flag_o,
   input wire logic discharge_overtemp_flag_o,
   input wire logic [2:0] mode_o
);
   logic [15:0] otc_t_q;
   logic [15:0] otd_t_q;
   logic [1:0] dflt_q;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // shadows of written hold times and untouched defaults
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         otc_t_q <= 16'hFFFF;
         otd_t_q <= 16'hFFFF;
         dflt_q <= 2'h3;
      end
      else if (wr_i)
      begin
         if (addr_i == `A_OTC_TIME)
            otc_t_q <= wdata_i;
         if (addr_i == `A_OTD_TIME)
            otd_t_q <= wdata_i;
         if (addr_i == `A_CFG)
            dflt_q[0] <= 1'b0;
         if (addr_i == `A_CHGV)
            dflt_q[1] <= 1'b0;
      end
   otc_off_a: assert property (otc_t_q == 16'h0000 |-> !$rose(charge_overtemp_flag_o))
      else $error("charge flag rose with zero hold");
   otd_off_a: assert property (otd_t_q == 16'h0000 |-> !$rose(discharge_overtemp_flag_o))
      else $error("discharge flag rose with zero hold");
   cfg_default_a: assert property (rd_i && addr_i == `A_CFG && dflt_q[0]
      |=> rdata_o == `CFG_RESET)
      else $error("config reset value wrong");
   chgv_default_a: assert property (rd_i && addr_i == `A_CHGV && dflt_q[1]
      |=> rdata_o == `CHGV_RESET)
      else $error("charging voltage reset value wrong");
   sleep_cal_a: assert property ($rose(mode_o == `M_SLEEP) |-> $past(mode_o) == `M_CAL)
      else $error("sleep entered without calibration");
   hib_hold_a: assert property ($fell(mode_o == `M_HIB)
      |-> $past(bus_addressed_i) || $past(bus_addressed_i, 2))
      else $error("deep low-power left without command");
   hib_wake_a: assert property (mode_o == `M_HIB && bus_addressed_i
      |-> ##[1:4] mode_o != `M_HIB)
      else $error("deep low-power not left on command");
   fast_oscillator_sleep_enable_wake_a: assert property (mode_o == `M_FAST_OSCILLATOR_SLEEP_ENABLE && bus_addressed_i
      |-> ##[1:4] mode_o != `M_FAST_OSCILLATOR_SLEEP_ENABLE)
      else $error("fast-wake sleep not left on command");
   good_present_a: assert property ($rose(battery_good_o) |-> battery_present_i)
      else $error("battery good without battery");
endmodule // gauge_pm_properties
bind gauge_power_mode_status_ctrl gauge_pm_properties chk_u (
   .clk_i(clk_i),
   .nrst_i(nrst_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o),
   .bus_addressed_i(bus_addressed_i),
   .battery_present_i(battery_present_i),
   .battery_good_o(battery_good_o),
   .charge_overtemp_flag_o(charge_overtemp_flag_o),
   .discharge_overtemp_flag_o(discharge_overtemp_flag_o),
   .mode_o(mode_o)
);
`default_nettype wire

// ===== verification/host_link_model.sv
// host side of the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic to_us_i,
   output logic scl_o = 1'b1,
   output logic addressed_o = 1'b0
);
   // host wakes gauge
   // bus clock at 200 ns, idle high between frames, then match pulse
   always @(posedge clk_i)
      if (go_i)
      begin
         // keep bus edges off the sampling clock edge
         #5;
         repeat (8)
         begin
            #100 scl_o = 1'b0;
            #100 scl_o = 1'b1;
         end
         @(posedge clk_i);
         addressed_o <= to_us_i;
         @(posedge clk_i);
         addressed_o <= 1'b0;
      end
endmodule // host_link_model
`default_nettype wire

// ===== verification/gauge_power_mode_status_ctrl_tb_top.sv
// self-checking bench for the gauge controller
`timescale 1ns/100ps
`default_nettype none
`include "gauge_pm_regs.vh"
module gauge_power_mode_status_ctrl_tb_top;
   localparam int MODE = 4;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] temp = 16'h00FA;
   logic [15:0] cur = 16'h0064;
   logic [15:0] volt = 16'h0FA0;
   logic wake_i = 1'b0;
   logic present = 1'b1;
   logic ext = 1'b0;
   logic cal_done_i = 1'b0;
   logic go = 1'b0;
   logic to_us = 1'b0;
   logic [15:0] d;
   wire [15:0] rdata_o;
   wire [2:0] mode_o;
   wire [3:0] obs;
   wire scl;
   wire addressed;
   wire cal_start;
   int error_cnt = 0;
   int tests_run = 0;
   gauge_power_mode_status_ctrl #(.INSERT_CYCLES(20)) dut_u (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .thermistor_input_i(temp),
      .internal_temp_i(16'h0000),
      .voltage_i(volt),
      .avg_current_i(cur),
      .cap_change_i(16'h0000),
      .taper_tick_i(1'b0),
      .wake_i(wake_i),
      .bus_addressed_i(addressed),
      .battery_present_i(present),
      .ext_power_i(ext),
      .temp_query_i(1'b0),
      .cal_done_i(cal_done_i),
      .link_scl_i(scl),
      .battery_status_pin_o(obs[3]),
      .battery_good_o(obs[2]),
      .charge_overtemp_flag_o(obs[0]),
      .discharge_overtemp_flag_o(obs[1]),
      .charging_o(),
      .measure_tick_o(),
      .cal_start_o(cal_start),
      .ram_reinit_o(),
      .mode_o(mode_o)
   );
   host_link_model host_u (
      .clk_i(clk_i),
      .go_i(go),
      .to_us_i(to_us),
      .scl_o(scl),
      .addressed_o(addressed)
   );
   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;
   // calibration answers one cycle after it starts
   always @(posedge clk_i)
      cal_done_i <= cal_start;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   function automatic logic [2:0] look(input int s);
      return (s < 4) ? {2'h0, obs[s]} : mode_o;
   endfunction
   task automatic wait_for(input int s, input logic [2:0] v, input int lim);
      int n;
      n = 0;
      while (look(s) !== v && n < lim)
      begin
         @(posedge clk_i);
         #1 n = n + 1;
      end
      check({13'h0000, look(s)}, {13'h0000, v});
   endtask
   task automatic frame(input logic us);
      to_us <= us;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
   endtask
   task automatic idle_mode(input logic [2:0] m);
      repeat (100) @(posedge clk_i);
      #1 check({13'h0000, mode_o}, {13'h0000, m});
   endtask
   task automatic t_defaults;
      rd(`A_CFG, d);
      check(d, `CFG_RESET);
      rd(`A_CHGV, d);
      check(d, `CHGV_RESET);
      wr(`A_CHGV, 16'h1004);
      rd(`A_CHGV, d);
      check(d, 16'h1004);
   endtask
   task automatic t_overtemp;
      wr(`A_OTC_THR, 16'h01C2);
      wr(`A_OTC_REC, 16'h0190);
      wr(`A_OTC_TIME, 16'h0005);
      wr(`A_OTD_THR, 16'h01C2);
      wr(4'h7, 16'hEC14);
      temp <= 16'h01F4;
      wait_for(0, 3'h1, 60);
      temp <= 16'h0190;
      wait_for(0, 3'h0, 30);
      wr(`A_OTC_TIME, 16'h0000);
      wr(`A_OTD_TIME, 16'h0000);
      temp <= 16'h01F4;
      cur <= 16'hFF9C;
      repeat (60) @(posedge clk_i);
      #1 check({14'h0000, obs[1:0]}, 16'h0000);
      temp <= 16'h00FA;
      cur <= 16'h0064;
   endtask
   task automatic t_sleep;
      wr(`A_CUR, 16'h3232);
      cur <= 16'h000A;
      wait_for(MODE, `M_SLEEP, 300);
      wake_i <= 1'b1;
      wait_for(MODE, `M_NORMAL, 50);
      wake_i <= 1'b0;
      wait_for(MODE, `M_SLEEP, 300);
      cur <= 16'h0064;
      wait_for(MODE, `M_NORMAL, 300);
   endtask
   task automatic t_fast_oscillator_sleep_enable;
      wr(`A_CFG, 16'h0911);
      wr(`A_CTRL, 16'h0001);
      cur <= 16'h000A;
      wait_for(MODE, `M_FAST_OSCILLATOR_SLEEP_ENABLE, 100);
      frame(1'b1);
      wait_for(MODE, `M_NORMAL, 120);
      wait_for(MODE, `M_FAST_OSCILLATOR_SLEEP_ENABLE, 100);
      cur <= 16'h0064;
      wait_for(MODE, `M_NORMAL, 50);
      wr(`A_CTRL, 16'h0000);
   endtask
   task automatic t_hib;
      cur <= 16'h000A;
      wr(`A_CTRL, 16'h0012);
      wait_for(MODE, `M_HIB, 100);
      cur <= 16'h0064;
      frame(1'b0);
      idle_mode(`M_HIB);
      frame(1'b1);
      wait_for(MODE, `M_NORMAL, 120);
      wr(`A_CTRL, 16'h0000);
   endtask
   task automatic t_insert;
      ext <= 1'b1;
      present <= 1'b0;
      wait_for(MODE, `M_INSERT, 50);
      frame(1'b1);
      idle_mode(`M_INSERT);
      present <= 1'b1;
      wait_for(2, 3'h1, 100);
      wait_for(MODE, `M_NORMAL, 100);
      // inhibit window 5..50 with zero hysteresis
      temp <= 16'h0014;
      wr(`A_MEAS, 16'h3205);
      wait_for(3, 3'h0, 20);
      temp <= 16'h0064;
      wait_for(3, 3'h1, 20);
      temp <= 16'h00FA;
   endtask
   task automatic t_swreset;
      wr(`A_CTRL, 16'h000C);
      repeat (20) @(posedge clk_i);
      rd(`A_RSTCNT, d);
      check(d, 16'h0001);
      wr(`A_CTRL, 16'h0004);
      repeat (20) @(posedge clk_i);
      rd(`A_RSTCNT, d);
      check(d, 16'h0101);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog against a hung wait
   initial
   begin
      #500000;
      error_cnt++;
      close_out();
   end
   // reset, then the scenarios in turn
   initial
   begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_defaults();
      t_overtemp();
      t_sleep();
      t_fast_oscillator_sleep_enable();
      t_hib();
      t_insert();
      t_swreset();
      close_out();
   end
endmodule // gauge_power_mode_status_ctrl_tb_top
`default_nettype wire
